/* shared/cfg_loader_pkg.sv */
/*
 * constants for the register commit and nonvolatile script loader.
 * assumes a byte-wide register port and a byte-wide nonvolatile store port.
 */
package cfg_loader_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          BANK_DEPTH      = 256;
    localparam int          BANK_AW         = 8;
    localparam int          SCRIPT_DEPTH    = 256;
    localparam int          SCRIPT_AW       = 8;
    localparam int          NV_AW           = 8;
    // register map
    localparam logic [11:0] BANK_LAST       = 12'h0FF;
    localparam logic [11:0] COMMIT_ADDR     = 12'h232;
    localparam logic [11:0] SCRIPT_BASE     = 12'hA00;
    localparam logic [11:0] SCRIPT_LAST     = 12'hAFF;
    localparam logic [11:0] STATUS_ADDR     = 12'hB00;
    localparam logic [11:0] NV_CTRL_ADDR    = 12'hB02;
    localparam logic [11:0] SAVE_ADDR       = 12'hB03;
    // field positions
    localparam int          COMMIT_BIT      = 0;
    localparam int          BUSY_BIT        = 0;
    localparam int          WR_EN_BIT       = 0;
    localparam int          LOAD_BIT        = 1;
    localparam int          SAVE_BIT        = 0;
    localparam int          OP_FLAG_BIT     = 7;
    // script encodings
    localparam logic [7:0]  OP_COMMIT       = 8'h80;
    localparam logic [7:0]  OP_END          = 8'hFF;
    localparam logic [7:0]  DEF_XFER_CMD    = 8'h7F;
    localparam logic [7:0]  DEF_ADDR_HI     = 8'h00;
    localparam logic [7:0]  DEF_ADDR_LO0    = 8'h00;
    localparam logic [7:0]  DEF_ADDR_LO1    = 8'h80;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    // timing
    localparam int          CLK_MHZ         = 100;
    localparam int          GAP_US          = 10;
    localparam int          GAP_CYCLES      = GAP_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_HI    = 3'b010,
        ST_LO    = 3'b011,
        ST_MOVE  = 3'b100
    } interp_state_e;
endpackage

/* shared/script_if.sv */
/*
 * carrier between the register file and the script interpreter.
 * assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface script_if;
    import cfg_loader_pkg::*;
    logic                 start;
    logic                 save_dir;
    logic                 busy;
    logic                 commit_req;
    logic [SCRIPT_AW-1:0] scr_addr;
    logic [7:0]           scr_data;
    logic [ADDR_W-1:0]    buf_addr;
    logic [7:0]           buf_rdata;
    logic [7:0]           buf_wdata;
    logic                 buf_we;

    modport regs (output start, output save_dir, input busy, input commit_req, input scr_addr,
                  output scr_data, input buf_addr, output buf_rdata, input buf_wdata, input buf_we);
    modport interp (input start, input save_dir, output busy, output commit_req, output scr_addr,
                    input scr_data, output buf_addr, input buf_rdata, output buf_wdata, output buf_we);
endinterface

/* rtl/script_interp.sv */
/*
 * walks the script area and moves bytes between buffer registers and storage.
 * assumes the store answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps
module script_interp
    import cfg_loader_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    input  wire logic           clk_en,
    script_if.interp            sif,
    output logic                nv_req,
    output logic                nv_we,
    output logic [NV_AW-1:0]    nv_addr,
    output logic [7:0]          nv_wdata,
    input  wire logic [7:0]     nv_rdata,
    input  wire logic           nv_ack
);
    interp_state_e        state_q;
    logic                 dir_q;
    logic [SCRIPT_AW-1:0] sptr_q;
    logic [6:0]           left_q;
    logic [7:0]           hi_q;
    logic [ADDR_W-1:0]    baddr_q;
    logic [NV_AW-1:0]     naddr_q;
    logic                 commit_q;

    wire       is_op     = sif.scr_data[OP_FLAG_BIT];
    wire       is_end    = is_op && (sif.scr_data == OP_END);
    wire       is_commit = is_op && (sif.scr_data == OP_COMMIT);
    wire       last_scr  = (sptr_q == SCRIPT_AW'(SCRIPT_DEPTH - 1));
    wire       moving    = (state_q == ST_MOVE);
    wire       beat      = moving && nv_ack;

    assign sif.busy       = (state_q != ST_IDLE);
    assign sif.scr_addr   = sptr_q;
    assign sif.commit_req = commit_q;
    assign sif.buf_addr   = baddr_q;
    assign sif.buf_wdata  = nv_rdata;
    assign sif.buf_we     = beat && !dir_q;
    assign nv_req         = moving;
    assign nv_we          = moving && dir_q;
    assign nv_addr        = naddr_q;
    assign nv_wdata       = sif.buf_rdata;

    // ----------------------------------------
    // script walk
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q  <= ST_IDLE;
            dir_q    <= 1'b0;
            sptr_q   <= '0;
            left_q   <= '0;
            hi_q     <= '0;
            baddr_q  <= '0;
            naddr_q  <= '0;
            commit_q <= 1'b0;
        end
        else if (clk_en)
        begin
            commit_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (sif.start)
                    begin
                        state_q <= ST_CMD;
                        dir_q   <= sif.save_dir;
                        sptr_q  <= '0;
                        naddr_q <= '0;
                    end
                end
                ST_CMD:
                begin
                    if (!is_op)
                    begin
                        left_q  <= sif.scr_data[6:0];
                        state_q <= ST_HI;
                        sptr_q  <= sptr_q + 1'b1;
                    end
                    else if (is_end || last_scr)
                        state_q <= ST_IDLE;
                    else
                    begin
                        commit_q <= is_commit;
                        sptr_q   <= sptr_q + 1'b1;
                    end
                end
                ST_HI:
                begin
                    hi_q    <= sif.scr_data;
                    state_q <= ST_LO;
                    sptr_q  <= sptr_q + 1'b1;
                end
                ST_LO:
                begin
                    baddr_q <= ADDR_W'({hi_q, sif.scr_data});
                    state_q <= ST_MOVE;
                end
                ST_MOVE:
                begin
                    if (nv_ack)
                    begin
                        baddr_q <= baddr_q + 1'b1;
                        naddr_q <= naddr_q + 1'b1;
                        left_q  <= left_q - 1'b1;
                        if (left_q == 7'h00)
                        begin
                            state_q <= last_scr ? ST_IDLE : ST_CMD;
                            sptr_q  <= sptr_q + 1'b1;
                        end
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

/* rtl/cfg_loader.sv */
/*
 * buffered and active register banks, commit control, script area and
 * save/restore control registers of the configuration loader.
 * assumes the serial port decoder presents one-cycle register strobes on ref_clk
 * and that sclk_pin is the raw serial clock pin.
 */
`timescale 1ns/1ps
module cfg_loader
    import cfg_loader_pkg::*;
(
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    input  wire logic                             clk_en,
    input  wire logic                             sclk_pin,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [cfg_loader_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                       reg_wdata,
    output logic [7:0]                            reg_rdata,
    input  wire logic [cfg_loader_pkg::BANK_AW-1:0] act_addr,
    output logic [7:0]                            act_data,
    output logic                                  xfer_busy,
    output logic                                  nv_req,
    output logic                                  nv_we,
    output logic [cfg_loader_pkg::NV_AW-1:0]      nv_addr,
    output logic [7:0]                            nv_wdata,
    input  wire logic [7:0]                       nv_rdata,
    input  wire logic                             nv_ack
);
    import cfg_loader_pkg::*;

    script_if sif ();

    logic [7:0]  buf_q    [BANK_DEPTH];
    logic [7:0]  act_q    [BANK_DEPTH];
    logic [7:0]  script_q [SCRIPT_DEPTH];
    logic [2:0]  sclk_q;
    logic        commit_pend_q;
    logic        save_q;
    logic        load_q;
    logic        wr_en_q;
    logic        busy_q;
    logic        start_q;
    logic        dir_q;
    logic [7:0]  rdata_q;
    logic [7:0]  act_data_q;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire         hit_bank   = (reg_addr <= BANK_LAST);
    wire         hit_commit = (reg_addr == COMMIT_ADDR);
    wire         hit_script = (reg_addr >= SCRIPT_BASE) && (reg_addr <= SCRIPT_LAST);
    wire         hit_status = (reg_addr == STATUS_ADDR);
    wire         hit_nvctl  = (reg_addr == NV_CTRL_ADDR);
    wire         hit_save   = (reg_addr == SAVE_ADDR);
    wire [BANK_AW-1:0]   bank_idx   = reg_addr[BANK_AW-1:0];
    wire [SCRIPT_AW-1:0] script_idx = reg_addr[SCRIPT_AW-1:0];
    wire         wr         = clk_en && reg_wr;
    wire         sclk_rise  = sclk_q[1] && !sclk_q[2];
    wire         host_commit = commit_pend_q && sclk_rise;
    wire         do_commit  = host_commit || sif.commit_req;
    wire         sif_bank   = (sif.buf_addr <= BANK_LAST);
    wire [BANK_AW-1:0] sif_idx = sif.buf_addr[BANK_AW-1:0];
    wire         busy_fall  = busy_q && !sif.busy;
    wire         save_go    = wr && hit_save && reg_wdata[SAVE_BIT] && wr_en_q && !sif.busy;
    wire         load_go    = wr && hit_nvctl && reg_wdata[LOAD_BIT] && !sif.busy;

    assign sif.start     = start_q;
    assign sif.save_dir  = dir_q;
    assign sif.scr_data  = script_q[sif.scr_addr];
    assign sif.buf_rdata = sif_bank ? buf_q[sif_idx] : BYTE_ZERO;
    assign reg_rdata     = rdata_q;
    assign act_data      = act_data_q;
    assign xfer_busy     = busy_q;

    script_interp i_script_interp (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .sif      (sif.interp),
        .nv_req   (nv_req),
        .nv_we    (nv_we),
        .nv_addr  (nv_addr),
        .nv_wdata (nv_wdata),
        .nv_rdata (nv_rdata),
        .nv_ack   (nv_ack)
    );

    // ----------------------------------------
    // serial clock sync and commit
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sclk_q <= '0;
        else if (clk_en)
            sclk_q <= {sclk_q[1:0], sclk_pin};
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            commit_pend_q <= 1'b0;
        else if (clk_en)
        begin
            if (wr && hit_commit && reg_wdata[COMMIT_BIT])
                commit_pend_q <= 1'b1;
            else if (sclk_rise)
                commit_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // buffered and active banks
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            if (sif.buf_we && sif_bank)
                buf_q[sif_idx] <= sif.buf_wdata;
            else if (wr && hit_bank)
                buf_q[bank_idx] <= reg_wdata;
        end
    end

    for (genvar i = 0; i < BANK_DEPTH; i++)
    begin : g_active
        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
                act_q[i] <= BYTE_ZERO;
            else if (clk_en && do_commit)
                act_q[i] <= buf_q[i];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            act_data_q <= BYTE_ZERO;
        else if (clk_en)
            act_data_q <= act_q[act_addr];
    end

    // ----------------------------------------
    // script area with default contents
    // ----------------------------------------
    for (genvar j = 0; j < SCRIPT_DEPTH; j++)
    begin : g_script
        localparam logic [7:0] DEF = (j == 0) ? DEF_XFER_CMD :
                                     (j == 1) ? DEF_ADDR_HI  :
                                     (j == 2) ? DEF_ADDR_LO0 :
                                     (j == 3) ? DEF_XFER_CMD :
                                     (j == 4) ? DEF_ADDR_HI  :
                                     (j == 5) ? DEF_ADDR_LO1 :
                                     (j == 6) ? OP_COMMIT    : OP_END;
        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
                script_q[j] <= DEF;
            else if (wr && hit_script && (script_idx == SCRIPT_AW'(j)))
                script_q[j] <= reg_wdata;
        end
    end

    // ----------------------------------------
    // save / restore control
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            save_q  <= 1'b0;
            load_q  <= 1'b0;
            wr_en_q <= 1'b0;
            busy_q  <= 1'b0;
            start_q <= 1'b0;
            dir_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            busy_q  <= sif.busy || start_q;
            start_q <= save_go || load_go;
            if (save_go || load_go)
                dir_q <= save_go;
            if (wr && hit_nvctl)
                wr_en_q <= reg_wdata[WR_EN_BIT];
            if (save_go)
                save_q <= 1'b1;
            else if (busy_fall)
                save_q <= 1'b0;
            if (load_go)
                load_q <= 1'b1;
            else if (busy_fall)
                load_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_q <= BYTE_ZERO;
        else if (clk_en && reg_rd)
        begin
            if (hit_bank)
                rdata_q <= buf_q[bank_idx];
            else if (hit_script)
                rdata_q <= script_q[script_idx];
            else if (hit_status)
                rdata_q <= {7'h00, busy_q};
            else if (hit_nvctl)
                rdata_q <= {6'h00, load_q, wr_en_q};
            else if (hit_save)
                rdata_q <= {7'h00, save_q};
            else
                rdata_q <= BYTE_ZERO;
        end
    end
endmodule

/* verification/cfg_loader_chk.sv */
/*
 * port checker for the configuration loader.
 * assumes one ref_clk domain and a synchronous, active high sys_rst.
 */
`timescale 1ns/1ps
module cfg_loader_chk
    import cfg_loader_pkg::*;
(
    input wire logic                                ref_clk,
    input wire logic                                sys_rst,
    input wire logic                                clk_en,
    input wire logic                                reg_wr,
    input wire logic                                reg_rd,
    input wire logic [cfg_loader_pkg::ADDR_W-1:0]   reg_addr,
    input wire logic [7:0]                          reg_wdata,
    input wire logic [7:0]                          reg_rdata,
    input wire logic                                xfer_busy,
    input wire logic                                nv_req,
    input wire logic                                nv_we,
    input wire logic [cfg_loader_pkg::NV_AW-1:0]    nv_addr,
    input wire logic [7:0]                          nv_wdata,
    input wire logic                                nv_ack
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // storage link
    // ----------------------------------------
    req_hold_a: assert property (nv_req && !nv_ack && clk_en |=>
        nv_req && $stable(nv_addr) && $stable(nv_we) && $stable(nv_wdata))
        else $error("store request changed before ack");
    addr_step_a: assert property (clk_en && nv_req && nv_ack ##1 nv_req |->
        nv_addr == $past(nv_addr) + 8'h01)
        else $error("store address did not step by one");
    req_busy_a: assert property (nv_req |-> xfer_busy)
        else $error("store request outside a transfer");
    addr_fetch_a: assert property ($rose(xfer_busy) |-> !nv_req ##1 !nv_req)
        else $error("store request before address bytes fetched");
    first_addr_a: assert property ($rose(xfer_busy) |-> nv_addr == 8'h00)
        else $error("transfer does not start at store address zero");

    // ----------------------------------------
    // register port
    // ----------------------------------------
    restore_start_a: assert property (clk_en && reg_wr && reg_addr == NV_CTRL_ADDR
        && reg_wdata[LOAD_BIT] && !xfer_busy |-> ##[1:3] xfer_busy)
        else $error("restore trigger did not start a transfer");
    commit_reads_a: assert property (clk_en && reg_rd && reg_addr == COMMIT_ADDR
        |=> reg_rdata == 8'h00)
        else $error("commit register read nonzero");
    busy_read_a: assert property (clk_en && reg_rd && reg_addr == STATUS_ADDR
        |=> reg_rdata[BUSY_BIT] == $past(xfer_busy))
        else $error("status read disagrees with busy");
endmodule

bind cfg_loader cfg_loader_chk i_cfg_loader_chk (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .xfer_busy (xfer_busy),
    .nv_req    (nv_req),
    .nv_we     (nv_we),
    .nv_addr   (nv_addr),
    .nv_wdata  (nv_wdata),
    .nv_ack    (nv_ack)
);

/* verification/nv_store_model.sv */
/*
 * behavioural nonvolatile byte store on the storage link.
 * assumes requests hold until the one-cycle ack.
 */
`timescale 1ns/1ps
module nv_store_model
(
    input wire logic                              ref_clk,
    input wire logic                              slow,
    input wire logic                              nv_req,
    input wire logic                              nv_we,
    input wire logic [cfg_loader_pkg::NV_AW-1:0]  nv_addr,
    input wire logic [7:0]                        nv_wdata,
    output logic [7:0]                            nv_rdata,
    output logic                                  nv_ack
);
    logic [7:0] mem [256];
    int         wait_q = 0;

    initial nv_ack = 1'b0;
    initial nv_rdata = 8'h00;

    // ----------------------------------------
    // ack after a prompt or slow wait
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (nv_req && !nv_ack && wait_q >= (slow ? 3 : 0))
        begin
            nv_ack <= 1'b1;
            wait_q <= 0;
            if (nv_we)
                mem[nv_addr] <= nv_wdata;
            else
                nv_rdata <= mem[nv_addr];
        end
        else
        begin
            nv_ack <= 1'b0;
            // data line not held outside the ack cycle
            nv_rdata <= ~nv_rdata;
            if (nv_req && !nv_ack)
                wait_q <= wait_q + 1;
        end
    end
endmodule

/* verification/test_register_commit_and_eeprom_script.sv */
/*
 * testbench for the configuration loader: commit, script area, save, restore.
 * assumes the store model and the bound port checker.
 */
`timescale 1ns/1ps
module test_register_commit_and_eeprom_script;
    import cfg_loader_pkg::*;
    logic        ref_clk = 0, sys_rst = 1, clk_en = 1, sclk_pin = 0, slow = 0;
    logic        reg_wr = 0, reg_rd = 0, xfer_busy, nv_req, nv_we, nv_ack;
    logic [11:0] reg_addr = 0;
    logic [7:0]  reg_wdata = 0, act_addr = 0, reg_rdata, act_data, nv_addr, nv_wdata, nv_rdata;
    int          errors = 0, samples_checked = 0, acks = 0;
    logic [7:0]  dflt [9] = '{8'h7F, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h80, 8'h80, 8'hFF, 8'hFF};
    logic [7:0]  scr [8] = '{8'h01, 8'h00, 8'h10, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h20};

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (nv_ack) acks = acks + 1;

    cfg_loader i_cfg_loader (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .sclk_pin(sclk_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .act_addr(act_addr), .act_data(act_data),
        .xfer_busy(xfer_busy), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_ack(nv_ack));
    nv_store_model i_nv_store_model (.ref_clk(ref_clk), .slow(slow), .nv_req(nv_req),
        .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_ack(nv_ack));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    task act(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        act_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 chk("act_data", exp, act_data);
    endtask
    task sclk_pulse;
        @(posedge ref_clk);
        sclk_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        sclk_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task wait_busy(input logic lvl);
        int n;
        n = 0;
        while (xfer_busy !== lvl && n < 3000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("xfer_busy", lvl, xfer_busy);
    endtask
    task finish_test;
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        finish_test;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 9; k++) rd(SCRIPT_BASE + 12'(k), dflt[k]);
        rd(SCRIPT_LAST, 8'hFF);
        wr(12'h005, 8'h5A);
        wr(COMMIT_ADDR, 8'h01);
        sclk_pulse;
        act(8'h05, 8'h5A);
        wr(12'h005, 8'hA5);
        wr(COMMIT_ADDR, 8'h01);
        repeat (8) @(posedge ref_clk);
        act(8'h05, 8'h5A);
        sclk_pulse;
        act(8'h05, 8'hA5);
        wr(12'h005, 8'h3C);
        sclk_pulse;
        act(8'h05, 8'hA5);
        rd(COMMIT_ADDR, 8'h00);
        rd(12'h300, 8'h00);
        for (int i = 0; i < 256; i++) wr(12'(i), 8'(i) ^ 8'h5A);
        wr(SAVE_ADDR, 8'h01);
        repeat (10) @(posedge ref_clk);
        rd(STATUS_ADDR, 8'h00);
        wr(NV_CTRL_ADDR, 8'h01);
        acks = 0;
        wr(SAVE_ADDR, 8'h01);
        wait_busy(1'b1);
        rd(STATUS_ADDR, 8'h01);
        rd(SAVE_ADDR, 8'h01);
        wait_busy(1'b0);
        rd(SAVE_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h00);
        chk("acks", 16'd256, 16'(acks));
        for (int i = 0; i < 256; i++) chk("stored", 8'(i) ^ 8'h5A, i_nv_store_model.mem[i]);
        act(8'h20, 8'h7A);
        repeat (GAP_CYCLES) @(posedge ref_clk);
        wr(12'h010, 8'hC3);
        for (int k = 0; k < 8; k++) wr(SCRIPT_BASE + 12'(k), scr[k]);
        rd(SCRIPT_BASE + 12'h003, 8'h80);
        acks = 0;
        wr(SAVE_ADDR, 8'h01);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk("acks", 16'd2, 16'(acks));
        chk("stored", 8'hC3, i_nv_store_model.mem[0]);
        chk("stored", 8'h4B, i_nv_store_model.mem[1]);
        chk("stored", 8'h58, i_nv_store_model.mem[2]);
        act(8'h10, 8'hC3);
        repeat (GAP_CYCLES) @(posedge ref_clk);
        slow <= 1'b1;
        i_nv_store_model.mem[0] = 8'h96;
        i_nv_store_model.mem[1] = 8'h69;
        wr(NV_CTRL_ADDR, 8'h03);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(12'h010, 8'h96);
        rd(12'h011, 8'h69);
        act(8'h10, 8'h96);
        rd(NV_CTRL_ADDR, 8'h01);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(12'h010, 8'h55);
        clk_en <= 1'b1;
        rd(12'h010, 8'h96);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(SCRIPT_BASE + 12'h005, 8'h80);
        rd(STATUS_ADDR, 8'h00);
        finish_test;
    end
endmodule
